// ===== shared/sem_pkg.sv
// Purpose: constants shared by the safety error monitor and its checksum
// Assumes: word-wide AHB-Lite access, one register per aligned word
// Notes:   register offsets are indices; byte address is four times each
`default_nettype none

package sem_pkg;

  // ---------------------------------------------------------------
  // register indices
  // ---------------------------------------------------------------
  localparam logic [9:0] IDX_POWER_ENABLE    = 10'h042;
  localparam logic [9:0] IDX_ERR_CLEAR       = 10'h080;
  localparam logic [9:0] IDX_ERR_MASK        = 10'h081;
  localparam logic [9:0] IDX_ERR_SUMMARY     = 10'h082;
  localparam logic [9:0] IDX_ERR_CODE        = 10'h083;
  localparam logic [9:0] IDX_CHK_VALUE_LOW   = 10'h084;
  localparam logic [9:0] IDX_CHK_VALUE_HIGH  = 10'h085;
  localparam logic [9:0] IDX_MAP_CONTROL     = 10'h086;
  localparam logic [9:0] IDX_MAP_FINISHED    = 10'h087;
  localparam logic [9:0] IDX_MAP_RESULT_LOW  = 10'h088;
  localparam logic [9:0] IDX_MAP_RESULT_HIGH = 10'h089;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int ERR_N             = 6;
  localparam int BIT_CLK_LOSS      = 5;
  localparam int BIT_NEG_BIAS      = 4;
  localparam int BIT_POS_BIAS      = 3;
  localparam int BIT_REFERENCE     = 2;
  localparam int BIT_HEAT          = 1;
  localparam int BIT_CHECKSUM      = 0;
  localparam int BIT_CLEAR         = 0;
  localparam int BIT_SUMMARY       = 0;
  localparam int BIT_MAP_DISABLE   = 0;
  localparam int BIT_MAP_FINISHED  = 0;
  localparam int BIT_CLK_LOSS_EN   = 9;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] CLEAR_RST    = 16'h0000;
  localparam logic [15:0] MASK_RST     = 16'h0000;
  localparam logic [15:0] MAP_CTL_RST  = 16'h0000;
  localparam logic [15:0] CHK_RST      = 16'h0000;
  localparam logic        CLK_LOSS_EN_RST = 1'b1;

  // ---------------------------------------------------------------
  // checksum engine
  // ---------------------------------------------------------------
  localparam int          MAP_BITS  = 64;
  localparam logic [15:0] CRC_POLY  = 16'h1021;
  localparam logic [15:0] CRC_SEED  = 16'hFFFF;
  localparam logic [6:0]  MAP_LAST  = 7'h3F;

  typedef enum logic {CRC_IDLE, CRC_SHIFT} sem_crc_state_t;

endpackage

`default_nettype wire

// ===== logic/sem_crc_engine.sv
// Purpose: serial checksum over a snapshot of the writable register map
// Assumes: start is honoured only while idle
// Notes:   one map bit per clock, so a pass takes MAP_BITS cycles
`default_nettype none

module sem_crc_engine
  import sem_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  input  wire logic                start,
  input  wire logic [MAP_BITS-1:0] mapWord,
  output logic                     busy,
  output logic                     doneStrobe,
  output logic [15:0]              crcOut
);

  sem_crc_state_t        state_r;
  logic [MAP_BITS-1:0]   shift_r;
  logic [6:0]            count_r;
  logic [15:0]           crc_r;
  logic                  done_r;
  wire logic             feedBit;
  wire logic [15:0]      crc_nxt;

  assign feedBit    = crc_r[15] ^ shift_r[MAP_BITS-1];
  assign crc_nxt    = {crc_r[14:0], 1'b0} ^ (feedBit ? CRC_POLY : 16'h0000);
  assign busy       = (state_r == CRC_SHIFT);
  assign doneStrobe = done_r;
  assign crcOut     = crc_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= CRC_IDLE;
      shift_r <= '0;
      count_r <= 7'h00;
      crc_r   <= 16'h0000;
      done_r  <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (state_r)
        CRC_IDLE: begin
          if (start) begin
            shift_r <= mapWord;
            crc_r   <= CRC_SEED;
            count_r <= 7'h00;
            state_r <= CRC_SHIFT;
          end
        end
        CRC_SHIFT: begin
          crc_r   <= crc_nxt;
          shift_r <= {shift_r[MAP_BITS-2:0], 1'b0};
          count_r <= count_r + 7'h01;
          if (count_r == MAP_LAST) begin
            done_r  <= 1'b1;
            state_r <= CRC_IDLE;
          end
        end
        default: state_r <= CRC_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

// ===== logic/sem_monitor.sv
// Purpose: safety error monitor with register map checksum, AHB-Lite slave
// Assumes: detector inputs are asynchronous levels; one word per register
// Notes:   reads take one wait state, writes none; response always OKAY
//
// Operation
// - clear bit at 1 suppresses every safety error report.
// - clear bit 0 after reset; errors report normally; bits 15:1 reserved.
// - mask register bits 5..2 mask clock loss, biases, reference.
// - mask bit 1 heat, bit 0 checksum; all masks reset to 0.
// - summary flag reads 1 while any unmasked error present; resets 0.
// - error code register shows one bit per error source.
// - checksum value low byte read-only at 0x084, reset zero.
// - checksum value high byte read-only at 0x085, reset zero.
// - map checksum control bit: 0 runs calculation, 1 stops it.
// - finished bit reads 1 once map checksum completed, else 0.
// - map checksum result low byte read-only at 0x088.
// - map checksum result high byte read-only at 0x089.
// - clock loss detection counts only while power enable bit 9 is 1.
//
// Register access over AHB-Lite was chosen for this implementation.
`default_nettype none

module sem_monitor
  import sem_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // analog detector levels, asynchronous
  input  wire logic        clockLossDet,
  input  wire logic        negativeBiasDet,
  input  wire logic        positiveBiasDet,
  input  wire logic        referenceDet,
  input  wire logic        heatDet,
  // summary for the rest of the device
  output logic             safetyErrorSummary
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [ERR_N-1:1]      syncA_r;
  logic [ERR_N-1:1]      syncB_r;
  wire logic [ERR_N-1:1] detRaw;

  logic                  clear_r;
  logic [ERR_N-1:0]      mask_r;
  logic                  mapDisable_r;
  logic                  clkLossEn_r;

  logic [ERR_N-1:0]      code_r;
  logic [ERR_N-1:0]      code_nxt;
  logic                  summary_r;
  logic                  summary_nxt;
  wire logic [ERR_N-1:0] errEvent;

  logic [15:0]           chkValue_r;
  logic                  refValid_r;
  logic                  mapFinished_r;
  logic [15:0]           mapResult_r;
  logic                  dirty_r;
  logic                  dirtyRun_r;
  logic                  mismatch_r;

  wire logic             engBusy;
  wire logic             engDone;
  wire logic [15:0]      engCrc;
  wire logic             engStart;
  wire logic [MAP_BITS-1:0] mapWord;

  logic                  wrPend_r;
  logic [9:0]            wrIdx_r;
  logic                  rdPend_r;
  logic [9:0]            rdIdx_r;
  logic                  rdBad_r;
  logic [31:0]           hrdata_r;

  wire logic             accept;
  wire logic [9:0]       reqIdx;
  wire logic             reqBad;
  wire logic             wrClear;
  wire logic             wrMask;
  wire logic             wrMapCtl;
  wire logic             wrPower;
  wire logic             mapWrite;
  wire logic [15:0]      rdWord;

  // ---------------------------------------------------------------
  // detector synchronisers
  // ---------------------------------------------------------------
  assign detRaw = {clockLossDet, negativeBiasDet, positiveBiasDet,
                   referenceDet, heatDet};

  genvar g;
  generate
    for (g = 1; g < ERR_N; g++) begin : gSync
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          syncA_r[g] <= 1'b0;
          syncB_r[g] <= 1'b0;
        end else begin
          syncA_r[g] <= detRaw[g];
          syncB_r[g] <= syncA_r[g];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // error events
  // ---------------------------------------------------------------
  // clock loss only counts while its detector is powered
  assign errEvent[BIT_CLK_LOSS] =
    syncB_r[BIT_CLK_LOSS] & clkLossEn_r;
  assign errEvent[BIT_NEG_BIAS]  = syncB_r[BIT_NEG_BIAS];
  assign errEvent[BIT_POS_BIAS]  = syncB_r[BIT_POS_BIAS];
  assign errEvent[BIT_REFERENCE] = syncB_r[BIT_REFERENCE];
  assign errEvent[BIT_HEAT]      = syncB_r[BIT_HEAT];
  assign errEvent[BIT_CHECKSUM]  = mismatch_r;

  // ---------------------------------------------------------------
  // error code and summary
  // ---------------------------------------------------------------
  // the clear bit wins over a new event: nothing reports while it is held
  always_comb begin
    if (clear_r) begin
      code_nxt    = '0;
      summary_nxt = 1'b0;
    end else begin
      code_nxt    = code_r | errEvent;
      summary_nxt = |(code_nxt & ~mask_r);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      code_r    <= '0;
      summary_r <= 1'b0;
    end else begin
      code_r    <= code_nxt;
      summary_r <= summary_nxt;
    end
  end

  assign safetyErrorSummary = summary_r;

  // ---------------------------------------------------------------
  // bus address phase
  // ---------------------------------------------------------------
  assign accept = hsel & htrans[1] & hready;
  assign reqIdx = haddr[11:2];
  assign reqBad = (haddr[31:12] != 20'h0_0000) | (haddr[1:0] != 2'b00);

  assign hreadyout = ~rdPend_r;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_r <= 1'b0;
      wrIdx_r  <= 10'h000;
      rdPend_r <= 1'b0;
      rdIdx_r  <= 10'h000;
      rdBad_r  <= 1'b0;
    end else begin
      wrPend_r <= accept & hwrite & ~reqBad;
      rdPend_r <= accept & ~hwrite;
      if (accept) begin
        wrIdx_r <= reqIdx;
        rdIdx_r <= reqIdx;
        rdBad_r <= reqBad;
      end
    end
  end

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  assign wrClear  = wrPend_r & (wrIdx_r == IDX_ERR_CLEAR);
  assign wrMask   = wrPend_r & (wrIdx_r == IDX_ERR_MASK);
  assign wrMapCtl = wrPend_r & (wrIdx_r == IDX_MAP_CONTROL);
  assign wrPower  = wrPend_r & (wrIdx_r == IDX_POWER_ENABLE);
  assign mapWrite = wrClear | wrMask | wrMapCtl | wrPower;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clear_r      <= CLEAR_RST[BIT_CLEAR];
      mask_r       <= MASK_RST[ERR_N-1:0];
      mapDisable_r <= MAP_CTL_RST[BIT_MAP_DISABLE];
      clkLossEn_r  <= CLK_LOSS_EN_RST;
    end else begin
      if (wrClear) begin
        clear_r <= hwdata[BIT_CLEAR];
      end
      if (wrMask) begin
        mask_r <= hwdata[ERR_N-1:0];
      end
      if (wrMapCtl) begin
        mapDisable_r <= hwdata[BIT_MAP_DISABLE];
      end
      if (wrPower) begin
        clkLossEn_r <= hwdata[BIT_CLK_LOSS_EN];
      end
    end
  end

  // ---------------------------------------------------------------
  // register map checksum
  // ---------------------------------------------------------------
  // snapshot of every software-written bit; a flip here is an upset
  assign mapWord = {47'h0000_0000_0000, clkLossEn_r, mapDisable_r,
                    mask_r, 2'b00, clear_r, 6'h00};

  // runs back to back while enabled, low bit 0 meaning enabled
  assign engStart = ~mapDisable_r & ~engBusy & ~engDone;

  sem_crc_engine uEngine (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .start      (engStart),
    .mapWord    (mapWord),
    .busy       (engBusy),
    .doneStrobe (engDone),
    .crcOut     (engCrc)
  );

  // a write during a pass makes that pass stale: it becomes the new
  // reference instead of being compared
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      chkValue_r    <= CHK_RST;
      refValid_r    <= 1'b0;
      mapFinished_r <= 1'b0;
      mapResult_r   <= CHK_RST;
      dirty_r       <= 1'b0;
      dirtyRun_r    <= 1'b0;
      mismatch_r    <= 1'b0;
    end else begin
      mismatch_r <= 1'b0;
      if (engStart) begin
        dirtyRun_r <= dirty_r;
        dirty_r    <= mapWrite;
      end else if (mapWrite) begin
        dirty_r <= 1'b1;
      end
      if (mapWrite | mapDisable_r) begin
        mapFinished_r <= 1'b0;
      end else if (engDone & ~dirty_r) begin
        mapFinished_r <= 1'b1;
      end
      if (engDone) begin
        mapResult_r <= engCrc;
        if (~refValid_r | dirtyRun_r | dirty_r) begin
          chkValue_r <= engCrc;
          refValid_r <= 1'b1;
        end else if (engCrc != chkValue_r) begin
          mismatch_r <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  assign rdWord =
    rdBad_r                            ? 16'h0000 :
    (rdIdx_r == IDX_ERR_CLEAR)         ? {15'h0000, clear_r} :
    (rdIdx_r == IDX_ERR_MASK)          ? {10'h000, mask_r} :
    (rdIdx_r == IDX_ERR_SUMMARY)       ? {15'h0000, summary_r} :
    (rdIdx_r == IDX_ERR_CODE)          ? {10'h000, code_r} :
    (rdIdx_r == IDX_CHK_VALUE_LOW)     ? {8'h00, chkValue_r[7:0]} :
    (rdIdx_r == IDX_CHK_VALUE_HIGH)    ? {8'h00, chkValue_r[15:8]} :
    (rdIdx_r == IDX_MAP_CONTROL)       ? {15'h0000, mapDisable_r} :
    (rdIdx_r == IDX_MAP_FINISHED)      ? {15'h0000, mapFinished_r} :
    (rdIdx_r == IDX_MAP_RESULT_LOW)    ? {8'h00, mapResult_r[7:0]} :
    (rdIdx_r == IDX_MAP_RESULT_HIGH)   ? {8'h00, mapResult_r[15:8]} :
    (rdIdx_r == IDX_POWER_ENABLE)      ? {6'h00, clkLossEn_r, 9'h000} :
                                         16'h0000;

  // one wait state lets a write just before this read land first
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_r <= 32'h0000_0000;
    end else if (rdPend_r) begin
      hrdata_r <= {16'h0000, rdWord};
    end
  end

endmodule

`default_nettype wire

// ===== test/sem_check_monitor.sv
// Purpose: bus and summary checks on the safety error monitor
// Assumes: one clock domain, reset active low
// Notes:   clear and mask are shadowed from observed write data phases
`default_nettype none

module sem_check_monitor
  import sem_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        clockLossDet,
  input wire logic        negativeBiasDet,
  input wire logic        positiveBiasDet,
  input wire logic        referenceDet,
  input wire logic        heatDet,
  input wire logic        safetyErrorSummary
);
  logic       take;
  logic       rdTake;
  logic [9:0] idx;
  logic       wrPend_r;
  logic [9:0] wrIdx_r;
  logic       clear_r;
  logic [5:0] mask_r;

  assign take   = hsel && htrans[1] && hready;
  assign rdTake = take && !hwrite;
  assign idx    = haddr[11:2];

  // shadows land on the data phase edge, as the slave commits writes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_r <= 1'b0;
      wrIdx_r  <= '0;
      clear_r  <= 1'b0;
      mask_r   <= '0;
    end else begin
      wrPend_r <= take && hwrite;
      wrIdx_r  <= idx;
      if (wrPend_r && wrIdx_r == IDX_ERR_CLEAR) begin
        clear_r <= hwdata[0];
      end
      if (wrPend_r && wrIdx_r == IDX_ERR_MASK) begin
        mask_r <= hwdata[5:0];
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_resp_okay: assert property (hresp == 1'b0)
    else $error("slave response not OKAY");
  a_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write data phase stretched");
  a_read_wait: assert property (
    rdTake |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_byte_regs: assert property (
    rdTake && idx >= IDX_CHK_VALUE_LOW && idx <= IDX_MAP_RESULT_HIGH
    |-> ##2 hrdata[31:8] == 24'h00_0000)
    else $error("checksum byte register upper bits set");
  a_unmapped_zero: assert property (
    rdTake && idx > IDX_MAP_RESULT_HIGH |-> ##2 hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_clear_quiets: assert property (
    clear_r && $past(clear_r) && $past(clear_r, 2) |-> !safetyErrorSummary)
    else $error("summary raised while clear held");
  a_mask_quiets: assert property (
    mask_r == 6'h3F && $past(mask_r, 3) == 6'h3F |-> !safetyErrorSummary)
    else $error("summary raised with every error masked");
  a_clear_code: assert property (
    rdTake && idx == IDX_ERR_CODE && clear_r |-> ##2 hrdata == 32'h0000_0000)
    else $error("code bits read nonzero while clear held");
endmodule

bind sem_monitor sem_check_monitor u_check (
  .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .clockLossDet(clockLossDet), .negativeBiasDet(negativeBiasDet),
  .positiveBiasDet(positiveBiasDet), .referenceDet(referenceDet),
  .heatDet(heatDet), .safetyErrorSummary(safetyErrorSummary)
);

`default_nettype wire

// ===== test/sem_host_model.sv
// Purpose: host processor model, single-word AHB-Lite master
// Assumes: each transfer is entered just after a rising edge
// Notes:   released address and data lines carry inverted junk
`default_nettype none

module sem_host_model (
  input  wire logic        ref_clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  output logic             rdValid,
  output logic [31:0]      rdData
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    hsel    = 1'b0;
    haddr   = 32'h0000_0000;
    htrans  = 2'b00;
    hwrite  = 1'b0;
    hsize   = 3'b010;
    hwdata  = 32'h0000_0000;
    rdValid = 1'b0;
    rdData  = 32'h0000_0000;
  end

  // hready and read data are taken as the rising edge samples them
  task automatic xfer(input logic wr, input logic [9:0] ix,
                      input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {20'h0_0000, ix, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    haddr  <= ~{20'h0_0000, ix, 2'b00};
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    hwdata  <= ~d;
    rdData  <= hrdata;
    rdValid <= !wr;
  endtask

  always @(posedge ref_clk) begin
    if (rdValid) begin
      rdValid <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// ===== test/safety_error_monitor_crc_test.sv
// Purpose: self-checking bench for the safety error monitor
// Assumes: host model drives the bus, bench drives the detectors
// Notes:   expected reads wait in a queue until the host returns data
`default_nettype none

module safety_error_monitor_crc_test
  import sem_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  localparam logic [31:0] NIL = 32'h0000_0000;
  localparam logic [31:0] ERR = 32'h0000_003E;

  logic        ref_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic [4:0]  det     = 5'h00;
  logic        hsel, hwrite, hreadyOut, hresp, rdValid, sumOut;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rdData, rnd;
  logic [31:0] expQ[$], maskQ[$];
  logic [5:0]  acc;
  logic [15:0] crcExp;
  int          err_total   = 0;
  int          checks_done = 0;
  int          cycles      = 0;

  always #25 ref_clk = ~ref_clk;

  sem_monitor DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyOut), .hreadyout(hreadyOut), .hresp(hresp),
    .hrdata(hrdata), .clockLossDet(det[4]), .negativeBiasDet(det[3]),
    .positiveBiasDet(det[2]), .referenceDet(det[1]), .heatDet(det[0]),
    .safetyErrorSummary(sumOut)
  );

  sem_host_model host (
    .ref_clk(ref_clk), .hready(hreadyOut), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .rdValid(rdValid), .rdData(rdData)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    if (err_total == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [9:0] ix, input logic [31:0] d);
    host.xfer(1'b1, ix, d);
  endtask

  task automatic rd(input logic [9:0] ix, input logic [31:0] e,
                    input logic [31:0] m);
    expQ.push_back(e & m);
    maskQ.push_back(m);
    host.xfer(1'b0, ix, NIL);
  endtask

  task automatic pulse(input int i);
    det <= det | (5'h01 << i);
    repeat (3) @(posedge ref_clk);
    det <= det & ~(5'h01 << i);
    repeat (6) @(posedge ref_clk);
  endtask

  function automatic logic [15:0] crcOf(input logic [63:0] s);
    logic [15:0] c;
    c = CRC_SEED;
    for (int i = 63; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ s[i]) ? CRC_POLY : 16'h0000);
    end
    return c;
  endfunction

  // reads complete in issue order, so the oldest note is the one due
  always @(posedge ref_clk) begin
    if (rdValid) begin
      check(rdData & maskQ.pop_front(), expQ.pop_front());
    end
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles > 5000) begin
      err_total++;
      wrap_up();
    end
  end

  initial begin
    void'($urandom(30510));
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    // all ten reads finish before the first checksum pass can end
    for (int k = 0; k < 10; k++) begin
      rd(IDX_ERR_CLEAR + 10'(k), NIL, ALL);
    end
    rd(IDX_POWER_ENABLE, 32'h0000_0200, ALL);
    wr(10'h08A, ALL);
    rd(10'h08A, NIL, ALL);
    wr(IDX_ERR_CLEAR, ALL);
    rd(IDX_ERR_CLEAR, 32'h0000_0001, ALL);
    wr(IDX_ERR_CLEAR, NIL);
    rnd = $urandom;
    wr(IDX_ERR_MASK, rnd);
    rd(IDX_ERR_MASK, rnd & 32'h0000_003F, ALL);
    wr(IDX_ERR_MASK, NIL);
    acc = 6'h00;
    for (int i = 0; i < 5; i++) begin
      pulse(i);
      acc[i + 1] = 1'b1;
      rd(IDX_ERR_CODE, {26'h000_0000, acc}, ERR);
      rd(IDX_ERR_SUMMARY, 32'h0000_0001, ALL);
    end
    check({31'h0000_0000, sumOut}, 32'h0000_0001);
    wr(IDX_ERR_MASK, 32'h0000_003F);
    repeat (3) @(posedge ref_clk);
    rd(IDX_ERR_SUMMARY, NIL, ALL);
    rd(IDX_ERR_CODE, ERR, ERR);
    check({31'h0000_0000, sumOut}, NIL);
    wr(IDX_ERR_MASK, 32'h0000_001E);
    repeat (3) @(posedge ref_clk);
    rd(IDX_ERR_SUMMARY, 32'h0000_0001, ALL);
    wr(IDX_ERR_MASK, NIL);
    wr(IDX_ERR_CLEAR, 32'h0000_0001);
    repeat (3) @(posedge ref_clk);
    rd(IDX_ERR_CODE, NIL, ALL);
    rd(IDX_ERR_SUMMARY, NIL, ALL);
    pulse(1);
    rd(IDX_ERR_CODE, NIL, ALL);
    wr(IDX_ERR_CLEAR, NIL);
    repeat (3) @(posedge ref_clk);
    rd(IDX_ERR_CODE, NIL, ERR);
    pulse(2);
    rd(IDX_ERR_CODE, 32'h0000_0008, ERR);
    wr(IDX_POWER_ENABLE, NIL);
    pulse(4);
    rd(IDX_ERR_CODE, 32'h0000_0008, ERR);
    wr(IDX_POWER_ENABLE, 32'h0000_0200);
    pulse(4);
    rd(IDX_ERR_CODE, 32'h0000_0028, ERR);
    repeat (200) @(posedge ref_clk);
    crcExp = crcOf({47'h0000_0000_0000, 1'b1, 1'b0, 6'h00, 3'h0, 6'h00});
    rd(IDX_MAP_FINISHED, 32'h0000_0001, ALL);
    rd(IDX_MAP_RESULT_LOW, 32'(crcExp[7:0]), ALL);
    rd(IDX_MAP_RESULT_HIGH, 32'(crcExp[15:8]), ALL);
    rd(IDX_CHK_VALUE_LOW, 32'(crcExp[7:0]), ALL);
    rd(IDX_CHK_VALUE_HIGH, 32'(crcExp[15:8]), ALL);
    wr(IDX_MAP_CONTROL, 32'h0000_0001);
    rd(IDX_MAP_CONTROL, 32'h0000_0001, ALL);
    rd(IDX_MAP_FINISHED, NIL, ALL);
    repeat (4) @(posedge ref_clk);
    wrap_up();
  end
endmodule

`default_nettype wire
